// [hdl/mcsd_defines.svh]
// Offsets, field positions, reset values and timing counts of the config store
`ifndef MCSD_DEFINES_SVH
`define MCSD_DEFINES_SVH

// ----------------------------------------------------------------
// Configuration bit addresses (field low bit, width)
// ----------------------------------------------------------------
`define MCSD_CFG_BITS 56
`define MCSD_ADDR_LOCK 6'h00
`define MCSD_ADDR_CLKRNG 6'h01
`define MCSD_ADDR_LEDLOW 6'h03
`define MCSD_ADDR_SENSOR 6'h05
`define MCSD_ADDR_FUNDAMENTAL_ONLY 6'h0A
`define MCSD_ADDR_NOLOAD 6'h0C
`define MCSD_ADDR_RATIO 6'h0E
`define MCSD_ADDR_BANDGAP_TEMP_TRIM 6'h12
`define MCSD_ADDR_PHASE 6'h14
`define MCSD_ADDR_VGAIN 6'h18
`define MCSD_ADDR_PGAIN 6'h20
`define MCSD_ADDR_SGAIN 6'h28
`define MCSD_ADDR_OSC 6'h30
`define MCSD_ADDR_NOM 6'h32
`define MCSD_ADDR_XGAIN 6'h34
`define MCSD_ADDR_TAMPER 6'h35
`define MCSD_ADDR_STYPE 6'h36

// ----------------------------------------------------------------
// Mode signal addresses and reset value
// ----------------------------------------------------------------
`define MCSD_ADDR_AUX 6'h38
`define MCSD_ADDR_PUMP 6'h39
`define MCSD_ADDR_RDSRC 6'h3D
`define MCSD_ADDR_FUSEWE 6'h3E
`define MCSD_MODE_RESET 1'h0
`define MCSD_CFG_RESET 56'h0

// ----------------------------------------------------------------
// Timing: clock rate and mono-flop pulse lengths
// ----------------------------------------------------------------
`define MCSD_CLK_MHZ 20
`define MCSD_PULSE_SHORT_US 31250
`define MCSD_PULSE_LONG_US 156250
`define MCSD_PULSE_SHORT_CYC (`MCSD_PULSE_SHORT_US * `MCSD_CLK_MHZ)
`define MCSD_PULSE_LONG_CYC (`MCSD_PULSE_LONG_US * `MCSD_CLK_MHZ)

`endif

// [hdl/mcsd_pkg.sv]
// Types shared by the config store and stepper driver
package mcsd_pkg;

  // ----------------------------------------------------------------
  // Serial command receiver states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MCSD_RX_IDLE = 1'b0,
    MCSD_RX_SHIFT = 1'b1
  } mcsd_rx_state_t;

endpackage

// [hdl/mcsd_top.sv]
// Configuration-bit store, mode signals, LED divider and stepper driver
`timescale 1ns/1ps
`include "mcsd_defines.svh"

// Notes on behaviour
// - Motor pulse lasts 31.25 ms with stepper type 0, 156.25 ms with 1.
// - Stepper type 0: motor pulses are P/64, P/128, P/32, P/256.
// - Stepper type 1: motor pulses are P/640, P/1280, P/320, P/2560.
// - Divided pulses go alternately to coil A and coil B.
// - Negative power inverts both motor outputs.
// - No-load holds both motor outputs low.
// - LED carries P, or P divided by ratio code when low-rate set.
// - Every shadow latch clears on reset.
// - Source select high takes shadow latches, low takes antifuses.
// - Unprogrammed antifuses read zero.
// - Fused lock bit 0 ignores commands and drops shadow source.
// - Clock range bit at address 1 picks 4 MHz or 8 MHz range.
// - Sensor field at addresses 5..6 picks current sensor and gain.
// - Highest address of a field is its most significant bit.
// - Address 10 picks fundamental (1) or wide-band (0) energy.
// - No-load field 12..13 picks constant 800, 1600, 3200, 6400.
// - Four-bit phase trim, 0.0384 degree steps up to 0.576.
// - Eight-bit gain trims span -12.5 to +12.5 percent.
// - Oscillator trim: 0, +10, -10, 0 percent for codes 0..3.
// - Extra gain bit at 52 adds gain of 8 to current channels.
// - Tamper select at 53: 12.5 percent at 0, 6.25 at 1.
// - Four volatile mode signals, cleared at reset, serially written.
// - Command: data bit, 6-bit address, execute bit latches value.
// - Fuse write enable clear: shadow only; set: shadow and antifuse.
module mcsd_top #(
  parameter int unsigned SHORT_PULSE_CYC = `MCSD_PULSE_SHORT_CYC,
  parameter int unsigned LONG_PULSE_CYC = `MCSD_PULSE_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scs_b_in,
  input wire logic syn_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic energy_pulse_in,
  input wire logic energy_neg_in,
  input wire logic noload_in,
  output logic led_out,
  output logic motor_out_pos_out,
  output logic motor_out_neg_out,
  output logic coil_drive_a_out,
  output logic coil_drive_b_out,
  output logic config_lock_out,
  output logic clock_range_select_out,
  output logic led_low_rate_out,
  output logic [1:0] sensor_type_select_out,
  output logic fundamental_only_out,
  output logic [1:0] noload_threshold_out,
  output logic [1:0] stepper_ratio_out,
  output logic [1:0] bandgap_temp_trim_out,
  output logic [3:0] phase_trim_out,
  output logic [7:0] voltage_gain_trim_out,
  output logic [7:0] primary_gain_trim_out,
  output logic [7:0] secondary_gain_trim_out,
  output logic [1:0] oscillator_trim_out,
  output logic [1:0] nominal_voltage_scale_out,
  output logic extra_gain_out,
  output logic tamper_threshold_select_out,
  output logic stepper_type_select_out,
  output logic pump_mode_out,
  output logic latch_src_sel_out,
  output logic fuse_write_en_out,
  output logic aux_mode_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mcsd_pkg::mcsd_rx_state_t rx_state_r;
  mcsd_pkg::mcsd_rx_state_t rx_state_nxt;
  logic scl_d_r;
  logic scl_fall;
  logic link_act;
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic cmd_exec;
  logic cmd_data;
  logic [5:0] cmd_addr;
  logic cmd_in_map;
  logic [`MCSD_CFG_BITS-1:0] shadow_r;
  logic [`MCSD_CFG_BITS-1:0] fuse_r;
  logic [`MCSD_CFG_BITS-1:0] cfg;
  logic pump_r;
  logic rdsrc_r;
  logic fusewe_r;
  logic aux_r;
  logic lock_r;
  logic [11:0] step_div;
  logic [7:0] led_div;
  logic [11:0] step_cnt_r;
  logic [7:0] led_cnt_r;
  logic step_fire;
  logic led_fire;
  logic [21:0] mono_len;
  logic [21:0] mono_cnt_r;
  logic [21:0] led_mono_r;
  logic phase_r;
  logic coil_a_nxt;
  logic coil_b_nxt;
  logic coil_a_r;
  logic coil_b_r;
  logic mpos_r;
  logic mneg_r;
  logic led_r;

  // ----------------------------------------------------------------
  // Serial command receiver
  // ----------------------------------------------------------------

  // Link is active only while both select and sync are held low
  assign link_act = ~scs_b_in & ~syn_b_in;
  // Leading edge of the idle-high serial clock samples the data line
  assign scl_fall = scl_d_r & ~scl_in;

  // Previous serial clock level for edge detection
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      scl_d_r <= 1'h1;
    end else begin
      scl_d_r <= scl_in;
    end
  end

  // Receiver state choice; a fused lock keeps it idle until the next reset
  always_comb begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      mcsd_pkg::MCSD_RX_IDLE: begin
        if (link_act && !lock_r) begin
          rx_state_nxt = mcsd_pkg::MCSD_RX_SHIFT;
        end
      end
      mcsd_pkg::MCSD_RX_SHIFT: begin
        if (!link_act) begin
          rx_state_nxt = mcsd_pkg::MCSD_RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = mcsd_pkg::MCSD_RX_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_state_r <= mcsd_pkg::MCSD_RX_IDLE;
    end else begin
      rx_state_r <= rx_state_nxt;
    end
  end

  // Bit counter and shift register; a dropped link restarts framing
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
    end else if (rx_state_r != mcsd_pkg::MCSD_RX_SHIFT || !link_act) begin
      bit_cnt_r <= 3'h0;
    end else if (scl_fall) begin
      bit_cnt_r <= bit_cnt_r + 3'h1; // Wraps after the execute bit
      shift_r <= {shift_r[5:0], sda_in};
    end
  end

  // The eighth clock latches; its own data bit is ignored
  assign cmd_exec = (rx_state_r == mcsd_pkg::MCSD_RX_SHIFT) && link_act &&
                    scl_fall && (bit_cnt_r == 3'h7);
  assign cmd_data = shift_r[6];
  assign cmd_addr = shift_r[5:0];
  // Reserved and unassigned slots store harmlessly, nothing reads them
  assign cmd_in_map = ({2'h0, cmd_addr} < 8'(`MCSD_CFG_BITS));

  // ----------------------------------------------------------------
  // Shadow latches and antifuse array
  // ----------------------------------------------------------------

  // Shadow latches are volatile and clear on every reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      shadow_r <= `MCSD_CFG_RESET;
    end else if (cmd_exec && cmd_in_map) begin
      shadow_r[cmd_addr] <= cmd_data;
    end
  end

  // Antifuses start blank, clear on every reset, and writes can only blow them to one
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fuse_r <= `MCSD_CFG_RESET;
    end else if (cmd_exec && cmd_in_map && fusewe_r && cmd_data) begin
      fuse_r[cmd_addr] <= 1'h1;
    end
  end

  // Lock takes hold only when the select pin goes idle, so a fuse
  // sequence running inside one select period is not cut short
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      lock_r <= 1'h0;
    end else if (scs_b_in && fuse_r[`MCSD_ADDR_LOCK]) begin
      lock_r <= 1'h1;
    end
  end

  // Source select; once locked the shadows no longer count
  assign cfg = (rdsrc_r && !lock_r) ? shadow_r : fuse_r;

  // ----------------------------------------------------------------
  // Mode signals
  // ----------------------------------------------------------------

  // Four volatile mode bits written by the same command format
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pump_r <= `MCSD_MODE_RESET;
      rdsrc_r <= `MCSD_MODE_RESET;
      fusewe_r <= `MCSD_MODE_RESET;
      aux_r <= `MCSD_MODE_RESET;
    end else if (cmd_exec) begin
      if (cmd_addr == `MCSD_ADDR_PUMP) begin
        pump_r <= cmd_data;
      end
      if (cmd_addr == `MCSD_ADDR_RDSRC) begin
        rdsrc_r <= cmd_data;
      end
      if (cmd_addr == `MCSD_ADDR_FUSEWE) begin
        fusewe_r <= cmd_data;
      end
      if (cmd_addr == `MCSD_ADDR_AUX) begin
        aux_r <= cmd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration field outputs, msb at the highest address
  // ----------------------------------------------------------------
  assign config_lock_out = lock_r;
  assign clock_range_select_out = cfg[`MCSD_ADDR_CLKRNG];
  assign led_low_rate_out = cfg[`MCSD_ADDR_LEDLOW];
  assign sensor_type_select_out = cfg[6:5];
  assign fundamental_only_out = cfg[`MCSD_ADDR_FUNDAMENTAL_ONLY];
  assign noload_threshold_out = cfg[13:12];
  assign stepper_ratio_out = cfg[15:14];
  assign bandgap_temp_trim_out = cfg[19:18];
  assign phase_trim_out = cfg[23:20];
  assign voltage_gain_trim_out = cfg[31:24];
  assign primary_gain_trim_out = cfg[39:32];
  assign secondary_gain_trim_out = cfg[47:40];
  assign oscillator_trim_out = cfg[49:48];
  assign nominal_voltage_scale_out = cfg[51:50];
  assign extra_gain_out = cfg[`MCSD_ADDR_XGAIN];
  assign tamper_threshold_select_out = cfg[`MCSD_ADDR_TAMPER];
  assign stepper_type_select_out = cfg[`MCSD_ADDR_STYPE];
  assign pump_mode_out = pump_r;
  assign latch_src_sel_out = rdsrc_r;
  assign fuse_write_en_out = fusewe_r;
  assign aux_mode_out = aux_r;

  // ----------------------------------------------------------------
  // Divider ratios and pulse length
  // ----------------------------------------------------------------

  // Ratio codes map 0..3 to 64, 128, 32, 256; long type is ten-fold
  always_comb begin
    led_div = 8'h40;
    case (stepper_ratio_out)
      2'h0: led_div = 8'h40;
      2'h1: led_div = 8'h80;
      2'h2: led_div = 8'h20;
      2'h3: led_div = 8'h00; // 256 wraps to zero in eight bits
      default: led_div = 8'h40;
    endcase
  end

  // Stepper division from type and ratio code
  always_comb begin
    step_div = 12'h040;
    case ({stepper_type_select_out, stepper_ratio_out})
      3'h0: step_div = 12'h040;
      3'h1: step_div = 12'h080;
      3'h2: step_div = 12'h020;
      3'h3: step_div = 12'h100;
      3'h4: step_div = 12'h280;
      3'h5: step_div = 12'h500;
      3'h6: step_div = 12'h140;
      3'h7: step_div = 12'hA00;
      default: step_div = 12'h040;
    endcase
  end

  // Mono-flop length follows the stepper type
  assign mono_len = stepper_type_select_out ? 22'(LONG_PULSE_CYC) :
                    22'(SHORT_PULSE_CYC);

  // ----------------------------------------------------------------
  // Stepper divider, mono-flop and phase decoder
  // ----------------------------------------------------------------

  // Count energy pulses; fire once every step_div of them
  assign step_fire = energy_pulse_in && (step_cnt_r == step_div - 12'h001);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      step_cnt_r <= 12'h000;
    end else if (energy_pulse_in) begin
      step_cnt_r <= step_fire ? 12'h000 : step_cnt_r + 12'h001;
    end
  end

  // Mono-flop bounds each drive pulse; a new step restarts it
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mono_cnt_r <= 22'h000000;
    end else if (step_fire) begin
      mono_cnt_r <= mono_len;
    end else if (mono_cnt_r != 22'h000000) begin
      mono_cnt_r <= mono_cnt_r - 22'h000001;
    end
  end

  // Decoder toggles the coil on every divided pulse
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      phase_r <= 1'h1;
    end else if (step_fire) begin
      phase_r <= ~phase_r;
    end
  end

  assign coil_a_nxt = (mono_cnt_r != 22'h000000) && !phase_r;
  assign coil_b_nxt = (mono_cnt_r != 22'h000000) && phase_r;

  // Motor pins: no-load beats the sign inversion
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      coil_a_r <= 1'h0;
      coil_b_r <= 1'h0;
      mpos_r <= 1'h0;
      mneg_r <= 1'h0;
    end else begin
      coil_a_r <= coil_a_nxt;
      coil_b_r <= coil_b_nxt;
      if (noload_in) begin
        mpos_r <= 1'h0;
        mneg_r <= 1'h0;
      end else begin
        mpos_r <= coil_a_nxt ^ energy_neg_in;
        mneg_r <= coil_b_nxt ^ energy_neg_in;
      end
    end
  end

  assign coil_drive_a_out = coil_a_r;
  assign coil_drive_b_out = coil_b_r;
  assign motor_out_pos_out = mpos_r;
  assign motor_out_neg_out = mneg_r;

  // ----------------------------------------------------------------
  // LED output
  // ----------------------------------------------------------------

  // An 8-bit counter divides by 256 because zero minus one is 8'hFF
  assign led_fire = energy_pulse_in && (led_cnt_r == led_div - 8'h01);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      led_cnt_r <= 8'h00;
    end else if (energy_pulse_in) begin
      led_cnt_r <= led_fire ? 8'h00 : led_cnt_r + 8'h01;
    end
  end

  // Low-rate LED pulses have the short fixed width
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      led_mono_r <= 22'h000000;
    end else if (led_fire) begin
      led_mono_r <= 22'(SHORT_PULSE_CYC);
    end else if (led_mono_r != 22'h000000) begin
      led_mono_r <= led_mono_r - 22'h000001;
    end
  end

  // Full rate mirrors the energy pulse, low rate uses the divider
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      led_r <= 1'h0;
    end else if (led_low_rate_out) begin
      led_r <= (led_mono_r != 22'h000000);
    end else begin
      led_r <= energy_pulse_in;
    end
  end

  assign led_out = led_r;

endmodule

// [tb/mcsd_properties.sv]
// Port-level checks on the config store and stepper driver
`timescale 1ns/1ps
module mcsd_properties #(
  parameter int unsigned SHORT_PULSE_CYC = 20,
  parameter int unsigned LONG_PULSE_CYC = 50
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic energy_pulse_in,
  input wire logic energy_neg_in,
  input wire logic noload_in,
  input wire logic led_out,
  input wire logic motor_out_pos_out,
  input wire logic motor_out_neg_out,
  input wire logic coil_drive_a_out,
  input wire logic coil_drive_b_out,
  input wire logic config_lock_out,
  input wire logic led_low_rate_out,
  input wire logic [1:0] stepper_ratio_out,
  input wire logic extra_gain_out,
  input wire logic stepper_type_select_out,
  input wire logic latch_src_sel_out,
  input wire logic fuse_write_en_out,
  input wire logic pump_mode_out,
  input wire logic aux_mode_out
);
  logic [31:0] hi_cnt_r;
  logic fuse_used_r;
  logic [4:0] cfg;
  logic [3:0] modes;
  assign cfg = {stepper_ratio_out, extra_gain_out, led_low_rate_out,
    stepper_type_select_out};
  assign modes = {latch_src_sel_out, fuse_write_en_out, pump_mode_out,
    aux_mode_out};
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // Coil A high time; a plain repetition cannot reach the long pulse
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      hi_cnt_r <= 32'h0;
    end else begin
      hi_cnt_r <= coil_drive_a_out ? hi_cnt_r + 32'h1 : 32'h0;
    end
  end
  // Fuse array is blank until a fuse write was ever enabled
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fuse_used_r <= 1'b0;
    end else if (fuse_write_en_out) begin
      fuse_used_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_mono_length: assert property ($fell(coil_drive_a_out) |->
    hi_cnt_r == (stepper_type_select_out ? LONG_PULSE_CYC : SHORT_PULSE_CYC))
    else $error("coil pulse length wrong");
  a_step_cause: assert property (
    $rose(coil_drive_a_out) || $rose(coil_drive_b_out)
    |-> $past(energy_pulse_in, 2)) else $error("step without energy pulse");
  a_motor_polarity: assert property (
    $past(rst_b_in) && !noload_in && !$past(noload_in) && !pump_mode_out
    && !$past(pump_mode_out) && $stable(energy_neg_in)
    |-> motor_out_pos_out == (coil_drive_a_out ^ energy_neg_in)
    && motor_out_neg_out == (coil_drive_b_out ^ energy_neg_in))
    else $error("motor pins do not follow coils");
  a_noload_low: assert property (
    noload_in && $past(noload_in) && !pump_mode_out
    |-> !motor_out_pos_out && !motor_out_neg_out)
    else $error("motor pins not low at no-load");
  a_led_full_rate: assert property (
    $past(rst_b_in) && !led_low_rate_out && !$past(led_low_rate_out)
    |-> led_out == $past(energy_pulse_in)) else $error("led not a copy");
  a_reset_clear: assert property ($rose(rst_b_in) |->
    cfg == 5'h0 && modes == 4'h0 && !config_lock_out && !led_out)
    else $error("state not cleared by reset");
  a_fuse_blank: assert property (
    !fuse_used_r && !latch_src_sel_out |-> cfg == 5'h0 && !config_lock_out)
    else $error("blank fuse source not zero");
  a_lock_freeze: assert property (
    $past(config_lock_out) && config_lock_out
    |-> $stable(cfg) && $stable(modes)) else $error("locked state changed");
endmodule

bind mcsd_top mcsd_properties #(
  .SHORT_PULSE_CYC(SHORT_PULSE_CYC), .LONG_PULSE_CYC(LONG_PULSE_CYC)
) i_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .energy_pulse_in(energy_pulse_in),
  .energy_neg_in(energy_neg_in), .noload_in(noload_in), .led_out(led_out),
  .motor_out_pos_out(motor_out_pos_out),
  .motor_out_neg_out(motor_out_neg_out),
  .coil_drive_a_out(coil_drive_a_out), .coil_drive_b_out(coil_drive_b_out),
  .config_lock_out(config_lock_out), .led_low_rate_out(led_low_rate_out),
  .stepper_ratio_out(stepper_ratio_out), .extra_gain_out(extra_gain_out),
  .stepper_type_select_out(stepper_type_select_out),
  .latch_src_sel_out(latch_src_sel_out),
  .fuse_write_en_out(fuse_write_en_out), .pump_mode_out(pump_mode_out),
  .aux_mode_out(aux_mode_out)
);

// [tb/mcsd_host_model.sv]
// Serial configuration host driving the command link
`timescale 1ns/1ps
module mcsd_host_model (
  input wire logic clk_in,
  output logic scs_b_out,
  output logic syn_b_out,
  output logic scl_out,
  output logic sda_out
);
  // Idle link sits high, as the pull-ups leave it
  initial begin
    scs_b_out = 1'b1;
    syn_b_out = 1'b1;
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // One command per select period; lock only takes hold at idle
  task automatic send(input logic d, input logic [5:0] a);
    logic [7:0] cmd;
    cmd = {d, a, 1'b0};
    tick(1);
    scs_b_out = 1'b0;
    syn_b_out = 1'b0;
    tick(3);
    for (int i = 7; i >= 0; i--) begin
      sda_out = cmd[i];
      tick(2);
      scl_out = 1'b0;
      tick(2);
      scl_out = 1'b1;
    end
    tick(2);
    scs_b_out = 1'b1;
    syn_b_out = 1'b1;
    sda_out = 1'b1;
    tick(3);
  endtask
endmodule

// [tb/meter_config_and_stepper_drive_tb.sv]
// Self-checking bench for the config store and stepper driver
`timescale 1ns/1ps
`include "mcsd_defines.svh"
module meter_config_and_stepper_drive_tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ep = 1'b0;
  logic neg = 1'b0;
  logic noload = 1'b0;
  logic scs_b, syn_b, scl, sda, led, m_pos, m_neg, c_a, c_b, lock;
  logic xgain, llr, stype, src, we, pump, aux;
  logic [1:0] ratio;
  int miscompares = 0;
  int checks = 0;
  int nt [8] = '{64, 128, 32, 256, 640, 1280, 320, 2560};
  // Short pulses keep the stepper scenarios well inside the run budget
  always #25 clk_in = ~clk_in;
  mcsd_host_model i_host (.clk_in(clk_in), .scs_b_out(scs_b),
    .syn_b_out(syn_b), .scl_out(scl), .sda_out(sda));
  mcsd_top #(.SHORT_PULSE_CYC(20), .LONG_PULSE_CYC(50)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scs_b_in(scs_b),
    .syn_b_in(syn_b), .scl_in(scl), .sda_in(sda), .energy_pulse_in(ep),
    .energy_neg_in(neg), .noload_in(noload), .led_out(led),
    .motor_out_pos_out(m_pos), .motor_out_neg_out(m_neg),
    .coil_drive_a_out(c_a), .coil_drive_b_out(c_b),
    .config_lock_out(lock), .clock_range_select_out(),
    .led_low_rate_out(llr), .sensor_type_select_out(),
    .fundamental_only_out(), .noload_threshold_out(),
    .stepper_ratio_out(ratio), .bandgap_temp_trim_out(),
    .phase_trim_out(), .voltage_gain_trim_out(), .primary_gain_trim_out(),
    .secondary_gain_trim_out(), .oscillator_trim_out(),
    .nominal_voltage_scale_out(), .extra_gain_out(xgain),
    .tamper_threshold_select_out(), .stepper_type_select_out(stype),
    .pump_mode_out(pump), .latch_src_sel_out(src),
    .fuse_write_en_out(we), .aux_mode_out(aux));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic d, input logic [5:0] a);
    i_host.send(d, a);
  endtask
  task automatic set_f(input logic [5:0] base, input int w, input int v);
    for (int i = 0; i < w; i++) wr(v[i], base + 6'(i));
  endtask
  // Pulses three cycles apart so every coil and led edge is seen
  task automatic run(output int n, output int l, output logic [1:0] r);
    logic [1:0] cp;
    logic lp;
    n = 0;
    l = 0;
    r = 2'b00;
    while (r == 2'b00 && n < 8000) begin
      cp = {c_a, c_b};
      lp = led;
      ep = 1'b1;
      tick(1);
      ep = 1'b0;
      tick(2);
      n++;
      r = {c_a, c_b} & ~cp;
      if (led === 1'b1 && lp === 1'b0) l++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_modes();
    logic [5:0] ma [4];
    ma = '{`MCSD_ADDR_AUX, `MCSD_ADDR_PUMP, `MCSD_ADDR_RDSRC,
      `MCSD_ADDR_FUSEWE};
    chk({lock, llr, stype, xgain, ratio, c_a, c_b, led}, 16'h0);
    for (int i = 0; i < 4; i++) begin
      wr(1'b1, ma[i]);
      chk({we, src, pump, aux}, 16'h1 << i);
      wr(1'b0, ma[i]);
    end
  endtask
  task automatic t_shadow();
    wr(1'b1, `MCSD_ADDR_RDSRC);
    set_f(`MCSD_ADDR_RATIO, 2, 2);
    chk(ratio, 16'h2);
    wr(1'b1, 6'h0B);
    chk({lock, llr, stype, xgain, ratio}, 16'h2);
    wr(1'b0, `MCSD_ADDR_RDSRC);
    chk(ratio, 16'h0);
    wr(1'b1, `MCSD_ADDR_RDSRC);
    chk(ratio, 16'h2);
  endtask
  task automatic t_step();
    int n;
    int l;
    logic [1:0] ra;
    logic [1:0] rb;
    wr(1'b1, `MCSD_ADDR_LEDLOW);
    for (int k = 0; k < 8; k++) begin
      set_f(`MCSD_ADDR_STYPE, 1, k / 4);
      set_f(`MCSD_ADDR_RATIO, 2, k % 4);
      neg = (k >= 4);
      run(n, l, ra);
      run(n, l, rb);
      chk(n, nt[k]);
      chk(l, (k >= 4) ? 16'hA : 16'h1);
      chk(ra ^ rb, 16'h3);
      chk({m_pos, m_neg}, {c_a, c_b} ^ {neg, neg});
    end
    noload = 1'b1;
    tick(3);
    chk({m_pos, m_neg}, 16'h0);
    noload = 1'b0;
    neg = 1'b0;
  endtask
  task automatic t_lock();
    wr(1'b1, `MCSD_ADDR_FUSEWE);
    wr(1'b1, `MCSD_ADDR_XGAIN);
    wr(1'b0, `MCSD_ADDR_FUSEWE);
    wr(1'b0, `MCSD_ADDR_RDSRC);
    chk({xgain, ratio}, 16'h4);
    wr(1'b1, `MCSD_ADDR_FUSEWE);
    wr(1'b1, `MCSD_ADDR_LOCK);
    wr(1'b1, `MCSD_ADDR_RDSRC);
    chk({lock, src, xgain}, 16'h5);
    rst_b_in = 1'b0;
    tick(2);
    rst_b_in = 1'b1;
    tick(1);
    chk({lock, we, xgain}, 16'h0);
  endtask
  // Watchdog well above the expected run of some 34000 cycles
  initial begin
    #(95000 * 50);
    miscompares++;
    give_verdict();
  end
  initial begin
    tick(20);
    rst_b_in = 1'b1;
    tick(1);
    t_modes();
    t_shadow();
    t_step();
    t_lock();
    give_verdict();
  end
endmodule
